/* File: rtl/cps_sequencer.sv */
// cabinet power and reset sequencer with apb registers
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "cps_defs.svh"
module cps_sequencer #(
	parameter int POR_CYC    = `CPS_POR_CYC,
	parameter int SETTLE_CYC = `CPS_SETTLE_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              clk_en,
	input  wire logic [11:0]       paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire cps_pkg::cps_pins_s pins,
	output logic                   supply_on_req,
	output cps_pkg::cps_en_t       mod_en_b,
	output logic                   sys_reset,
	output logic                   ac_low_warning,
	output cps_pkg::cps_piu_s      piu_status,
	output logic                   irq
);

	localparam logic [`CPS_TMR_W-1:0] POR_LD = `CPS_TMR_W'(POR_CYC);
	localparam logic [`CPS_TMR_W-1:0] SET_LD = `CPS_TMR_W'(SETTLE_CYC);
	localparam logic [`CPS_TMR_W-1:0] GAP_LD = `CPS_TMR_W'(`CPS_GAP_CYC);

	cps_pkg::cps_pins_s   pin_s;
	cps_pkg::cps_state_e  state_q;
	cps_pkg::cps_state_e  state_d;
	logic                 tmr_load;
	logic [`CPS_TMR_W-1:0] tmr_val;
	logic                 tmr_done;
	logic                 down_req;
	logic                 force_q;
	logic [`CPS_EV_W-1:0] ev_q;
	logic [`CPS_EV_W-1:0] ev_set;
	logic [`CPS_EV_W-1:0] mask_q;
	logic                 ot_prev_q;
	logic                 bl_prev_q;
	logic                 ac_prev_q;
	logic                 setup_rd;
	logic                 acc;
	logic                 hit;
	logic                 wr_en;
	logic                 rd_clr;
	logic [31:0]          rd_mux;

	// ==========================================================
	// pin synchronisers and delay timer
	cps_sync #(
		.W($bits(cps_pkg::cps_pins_s))
	) u_sync (
		.sys_clk(sys_clk),
		.rst_b  (rst_b),
		.ce     (clk_en),
		.d_in   (pins),
		.d_out  (pin_s)
	);

	cps_timer #(
		.RST_VAL(POR_LD)
	) u_tmr (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.ce      (clk_en),
		.load    (tmr_load),
		.load_val(tmr_val),
		.done    (tmr_done)
	);

	// ==========================================================
	// sequencing state machine
	// no battery input exists; only output-good loss and the force bit request power-down
	assign down_req = !pin_s.regulator_output_good || force_q;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			cps_pkg::ST_POR:
				if (tmr_done)
					state_d = cps_pkg::ST_OFF;
			cps_pkg::ST_OFF:
				if (pin_s.key_on && !force_q)
					state_d = cps_pkg::ST_BULK;
			cps_pkg::ST_BULK:
				if (pin_s.blower_ok && pin_s.regulator_output_good)
					state_d = cps_pkg::ST_MOD;
			cps_pkg::ST_MOD:
				if (down_req)
					state_d = cps_pkg::ST_PDA;
				else if (pin_s.mod_good && tmr_done)
					state_d = cps_pkg::ST_REL;
			cps_pkg::ST_REL:
				if (down_req)
					state_d = cps_pkg::ST_PDA;
				else if (tmr_done)
					state_d = cps_pkg::ST_RUN;
			cps_pkg::ST_RUN:
				if (down_req)
					state_d = cps_pkg::ST_PDA;
			cps_pkg::ST_PDA:
				if (tmr_done)
					state_d = cps_pkg::ST_PDR;
			cps_pkg::ST_PDR:
				if (tmr_done)
					state_d = cps_pkg::ST_IDLE;
			cps_pkg::ST_IDLE:
				if (pin_s.ac_ok && !force_q)
					state_d = cps_pkg::ST_BULK;
			default:
				state_d = cps_pkg::ST_POR;
		endcase
		if (state_q != cps_pkg::ST_POR && !pin_s.key_on)
			state_d = cps_pkg::ST_OFF;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			state_q <= cps_pkg::ST_POR;
		else if (clk_en)
			state_q <= state_d;
	end

	// timer reload on every state change
	assign tmr_load = clk_en && (state_d != state_q);

	always_comb
	begin
		case (state_d)
			cps_pkg::ST_MOD: tmr_val = SET_LD;
			cps_pkg::ST_REL: tmr_val = GAP_LD;
			cps_pkg::ST_PDA: tmr_val = GAP_LD;
			cps_pkg::ST_PDR: tmr_val = GAP_LD;
			default:         tmr_val = '0;
		endcase
	end

	// ==========================================================
	// power and reset outputs
	// reset and warning follow the next state, enables lag one cycle
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			sys_reset      <= 1'b1;
			ac_low_warning <= 1'b1;
			supply_on_req  <= 1'b0;
		end
		else if (clk_en)
		begin
			sys_reset      <= (state_d != cps_pkg::ST_RUN);
			ac_low_warning <= !(state_d == cps_pkg::ST_REL ||
				state_d == cps_pkg::ST_RUN);
			supply_on_req  <= (state_d == cps_pkg::ST_BULK ||
				state_d == cps_pkg::ST_MOD || state_d == cps_pkg::ST_REL ||
				state_d == cps_pkg::ST_RUN || state_d == cps_pkg::ST_PDA ||
				state_d == cps_pkg::ST_PDR);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			mod_en_b <= 3'h7;
		else if (clk_en)
		begin
			if (state_q == cps_pkg::ST_MOD || state_q == cps_pkg::ST_REL ||
				state_q == cps_pkg::ST_RUN || state_q == cps_pkg::ST_PDA ||
				state_q == cps_pkg::ST_PDR)
				mod_en_b <= 3'h0;
			else
				mod_en_b <= 3'h7;
		end
	end

	// plug-in unit status to the backplane
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			piu_status <= '0;
		else if (clk_en)
		begin
			piu_status.piu_a_ok <= pin_s.piu_a_ok;
			piu_status.piu_b_ok <= pin_s.piu_b_ok;
			piu_status.disk_ok  <= pin_s.disk_ok;
		end
	end

	// ==========================================================
	// events and interrupt
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			ot_prev_q <= 1'b0;
			bl_prev_q <= 1'b0;
			ac_prev_q <= 1'b0;
		end
		else if (clk_en)
		begin
			ot_prev_q <= pin_s.over_temp;
			bl_prev_q <= pin_s.blower_ok;
			ac_prev_q <= pin_s.ac_ok;
		end
	end

	always_comb
	begin
		ev_set = '0;
		ev_set[`CPS_EV_RUN] = tmr_load && state_d == cps_pkg::ST_RUN;
		ev_set[`CPS_EV_PD_START] = tmr_load && state_d == cps_pkg::ST_PDA;
		ev_set[`CPS_EV_PD_DONE] = tmr_load && state_d == cps_pkg::ST_IDLE;
		ev_set[`CPS_EV_OVERTEMP] = pin_s.over_temp && !ot_prev_q;
		ev_set[`CPS_EV_BLOWER] = !pin_s.blower_ok && bl_prev_q;
		ev_set[`CPS_EV_AC_BACK] = pin_s.ac_ok && !ac_prev_q;
		if (!clk_en || state_q == cps_pkg::ST_POR)
			ev_set = '0;
	end

	// only bits shown to the reader are cleared; a new set wins
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			ev_q <= '0;
		else if (clk_en)
			ev_q <= (ev_q & ~(rd_clr ? prdata[`CPS_EV_W-1:0] : '0)) | ev_set;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(ev_q & mask_q);
	end

	// ==========================================================
	// apb slave
	assign hit = (paddr == `CPS_OFF_STATUS) || (paddr == `CPS_OFF_EVENTS) ||
		(paddr == `CPS_OFF_MASK) || (paddr == `CPS_OFF_CTRL);
	assign acc      = psel && penable;
	assign pready   = clk_en;
	assign pslverr  = acc && !hit;
	assign setup_rd = clk_en && psel && !penable && !pwrite;
	assign wr_en    = clk_en && acc && pwrite;
	assign rd_clr   = clk_en && acc && !pwrite && paddr == `CPS_OFF_EVENTS;

	always_comb
	begin
		rd_mux = '0;
		case (paddr)
			`CPS_OFF_STATUS:
			begin
				rd_mux[8:0] = state_q;
				rd_mux[`CPS_STAT_PIN_LSB +: $bits(pin_s)] = pin_s;
			end
			`CPS_OFF_EVENTS: rd_mux[`CPS_EV_W-1:0] = ev_q;
			`CPS_OFF_MASK:   rd_mux[`CPS_EV_W-1:0] = mask_q;
			`CPS_OFF_CTRL:   rd_mux[`CPS_CTRL_FORCE] = force_q;
			default:         rd_mux = '0;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			prdata <= '0;
		else if (setup_rd)
			prdata <= rd_mux;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			mask_q  <= `CPS_MASK_RST;
			force_q <= `CPS_CTRL_RST;
		end
		else if (wr_en)
		begin
			if (paddr == `CPS_OFF_MASK)
				mask_q <= pwdata[`CPS_EV_W-1:0];
			if (paddr == `CPS_OFF_CTRL)
				force_q <= pwdata[`CPS_CTRL_FORCE];
		end
	end

	// ==========================================================
	// checks
	logic [23:0] por_cnt_q;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			por_cnt_q <= '0;
		else if (clk_en && por_cnt_q != 24'hFFFFFF)
			por_cnt_q <= por_cnt_q + 24'h000001;
	end

	key_off_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && !pin_s.key_on && state_q != cps_pkg::ST_POR
		|=> state_q == cps_pkg::ST_OFF)
		else $error("key off did not force off state");

	por_length_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$fell(state_q == cps_pkg::ST_POR)
		|-> por_cnt_q >= 24'(POR_CYC) && sys_reset)
		else $error("power-on hold ended early");

	start_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(state_q == cps_pkg::ST_MOD)
		|-> $past(pin_s.blower_ok && pin_s.key_on))
		else $error("power up without key or blower");

	pd_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && state_q == cps_pkg::ST_RUN && pin_s.key_on &&
		!pin_s.regulator_output_good
		|=> state_q == cps_pkg::ST_PDA ##1 ac_low_warning && sys_reset)
		else $error("output-good loss missed");

	idle_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == cps_pkg::ST_IDLE && $past(state_q) == cps_pkg::ST_IDLE
		|-> mod_en_b == 3'h7 && sys_reset)
		else $error("regulators on in idle");

	idle_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && state_q == cps_pkg::ST_IDLE && pin_s.key_on &&
		!pin_s.ac_ok |=> state_q == cps_pkg::ST_IDLE)
		else $error("left idle without ac");

	restart_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && state_q == cps_pkg::ST_IDLE && pin_s.key_on &&
		pin_s.ac_ok && !force_q
		|=> state_q == cps_pkg::ST_BULK ##1 supply_on_req)
		else $error("no restart on ac return");

	run_en_low_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == cps_pkg::ST_RUN |-> mod_en_b == 3'h0)
		else $error("regulators off while running");

	rst_before_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(mod_en_b[0]) |-> $past(sys_reset && ac_low_warning))
		else $error("regulator disabled before reset");

	release_ok_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$fell(sys_reset) |-> !ac_low_warning && mod_en_b == 3'h0)
		else $error("reset released too early");

	piu_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en ##1 1'b1 |-> piu_status.disk_ok == $past(pin_s.disk_ok))
		else $error("plug-in status not passed");

	run_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(state_q == cps_pkg::ST_RUN));
	idle_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(state_q == cps_pkg::ST_IDLE));
	restart_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == cps_pkg::ST_IDLE ##1 state_q == cps_pkg::ST_BULK);

endmodule

/* File: shared/cps_defs.svh */
// timing counts, register offsets, field positions and reset values
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH

// ==========================================================
// timing
`define CPS_CLK_KHZ     20000
`define CPS_POR_MS      400
`define CPS_POR_CYC     (`CPS_POR_MS * `CPS_CLK_KHZ)
`define CPS_GAP_US      10
`define CPS_GAP_CYC     ((`CPS_GAP_US * `CPS_CLK_KHZ + 999) / 1000)
`define CPS_SETTLE_US   1000
`define CPS_SETTLE_CYC  ((`CPS_SETTLE_US * `CPS_CLK_KHZ + 999) / 1000)
`define CPS_TMR_W       23

// ==========================================================
// register offsets
`define CPS_OFF_STATUS  12'h000
`define CPS_OFF_EVENTS  12'h004
`define CPS_OFF_MASK    12'h008
`define CPS_OFF_CTRL    12'h00C

// ==========================================================
// fields and reset values
`define CPS_EV_W        6
`define CPS_EV_RUN      0
`define CPS_EV_PD_START 1
`define CPS_EV_PD_DONE  2
`define CPS_EV_OVERTEMP 3
`define CPS_EV_BLOWER   4
`define CPS_EV_AC_BACK  5
`define CPS_STAT_PIN_LSB 16
`define CPS_CTRL_FORCE  0
`define CPS_MASK_RST    6'h00
`define CPS_CTRL_RST    1'b0

`endif

/* File: shared/cps_pkg.sv */
// types shared by the cabinet power sequencer
package cps_pkg;

	typedef enum logic [8:0] {
		ST_POR  = 9'h001,
		ST_OFF  = 9'h002,
		ST_BULK = 9'h004,
		ST_MOD  = 9'h008,
		ST_REL  = 9'h010,
		ST_RUN  = 9'h020,
		ST_PDA  = 9'h040,
		ST_PDR  = 9'h080,
		ST_IDLE = 9'h100
	} cps_state_e;

	typedef struct packed {
		logic key_on;
		logic blower_ok;
		logic regulator_output_good;
		logic ac_ok;
		logic mod_good;
		logic over_temp;
		logic piu_a_ok;
		logic piu_b_ok;
		logic disk_ok;
	} cps_pins_s;

	typedef struct packed {
		logic piu_a_ok;
		logic piu_b_ok;
		logic disk_ok;
	} cps_piu_s;

	typedef logic [2:0] cps_en_t;

endpackage

/* File: rtl/cps_sync.sv */
// two-flop synchroniser for the cabinet pins
`timescale 1ns/1ps
module cps_sync #(
	parameter int W = 9
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] d_out
);

	logic [W-1:0] meta_q;

	// ==========================================================
	// per bit stages
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge sys_clk)
			begin
				if (!rst_b)
				begin
					meta_q[i] <= 1'b0;
					d_out[i]  <= 1'b0;
				end
				else if (ce)
				begin
					meta_q[i] <= d_in[i];
					d_out[i]  <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

/* File: rtl/cps_timer.sv */
// loadable down counter for sequencer delays
`timescale 1ns/1ps
`include "cps_defs.svh"
module cps_timer #(
	parameter logic [`CPS_TMR_W-1:0] RST_VAL = '0
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	input  wire logic                  ce,
	input  wire logic                  load,
	input  wire logic [`CPS_TMR_W-1:0] load_val,
	output logic                       done
);

	logic [`CPS_TMR_W-1:0] cnt_q;

	// ==========================================================
	// count down to zero and hold
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			cnt_q <= RST_VAL;
		else if (ce)
		begin
			if (load)
				cnt_q <= load_val;
			else if (cnt_q != '0)
				cnt_q <= cnt_q - `CPS_TMR_W'(1);
		end
	end

	assign done = (cnt_q == '0);

endmodule

/* File: tb/cps_plant.sv */
// behavioural regulators, blower and module regulators
`timescale 1ns/1ps
module cps_plant #(
	parameter int TEST_CYC = 20,
	parameter int BLOW_CYC = 30,
	parameter int BATT_CYC = 100
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             supply_on_req,
	input  wire cps_pkg::cps_en_t mod_en_b,
	input  wire logic             ac_ok,
	input  wire logic             key_on,
	output logic                  reg_good,
	output logic                  blower_ok,
	output logic                  mod_good
);
	int test_q;
	int blow_q;
	int batt_q;
	int mod_q;

	// ==========================================================
	// bulk regulators
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b || !supply_on_req)
			test_q <= 0; // wait for request, then self-test
		else if (test_q < TEST_CYC)
			test_q <= test_q + 1;
		if (!rst_b || ac_ok)
			batt_q <= BATT_CYC;
		else if (batt_q != 0)
			batt_q <= batt_q - 1;
	end
	// battery carries only with key enabled
	assign reg_good = supply_on_req && test_q == TEST_CYC &&
		(ac_ok || (key_on && batt_q != 0));

	// ==========================================================
	// blower and module regulators
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b || !reg_good)
			blow_q <= 0;
		else if (blow_q < BLOW_CYC)
			blow_q <= blow_q + 1;
		if (!rst_b || mod_en_b !== 3'h0 || !reg_good)
			mod_q <= 0; // enable input active low
		else if (mod_q < 5)
			mod_q <= mod_q + 1;
	end
	assign blower_ok = blow_q == BLOW_CYC;
	assign mod_good = mod_q == 5;
endmodule

/* File: tb/cabinet_power_sequencer_tb_top.sv */
// self-checking bench for the cabinet power sequencer
`timescale 1ns/1ps
`include "cps_defs.svh"
module cabinet_power_sequencer_tb_top;
	logic                 sys_clk = 0;
	logic                 rst_b = 0;
	logic [11:0]          paddr = 12'h000;
	logic                 psel = 0;
	logic                 penable = 0;
	logic                 pwrite = 0;
	logic [31:0]          pwdata = 32'h00000000;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	cps_pkg::cps_pins_s   pins;
	logic                 supply_on_req;
	cps_pkg::cps_en_t     mod_en_b;
	logic                 sys_reset;
	logic                 ac_low_warning;
	cps_pkg::cps_piu_s    piu_status;
	logic                 irq;
	logic                 ce = 1;
	logic                 key = 0;
	logic                 ac = 1;
	logic                 ot = 0;
	logic [2:0]           piu = 3'h0;
	logic                 rg;
	logic                 blw;
	logic                 mg;
	int                   failures = 0;
	int                   tests_run = 0;
	logic [31:0]          d;
	logic                 e;

	always #25 sys_clk = ~sys_clk;
	assign pins = {key, blw, rg, ac, mg, ot, piu};

	cps_sequencer #(.POR_CYC(50), .SETTLE_CYC(10)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(ce),
		.paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(pins),
		.supply_on_req(supply_on_req), .mod_en_b(mod_en_b),
		.sys_reset(sys_reset), .ac_low_warning(ac_low_warning),
		.piu_status(piu_status), .irq(irq));
	cps_plant plant (
		.sys_clk(sys_clk), .rst_b(rst_b),
		.supply_on_req(supply_on_req), .mod_en_b(mod_en_b),
		.ac_ok(ac), .key_on(key), .reg_good(rg),
		.blower_ok(blw), .mod_good(mg));

	// ==========================================================
	// shared tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		tests_run++;
		if (seen !== ex)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wait_st(input logic [8:0] st, input int lim);
		int n;
		n = 0;
		apb(0, `CPS_OFF_STATUS, 0);
		while (d[8:0] !== st && n < lim)
		begin
			apb(0, `CPS_OFF_STATUS, 0);
			n++;
		end
		chk("state", d[8:0], st);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task t_reset;
		chk("sys_reset", sys_reset, 1);
		chk("ac_low", ac_low_warning, 1);
		chk("mod_en_b", mod_en_b, 3'h7);
		chk("supply", supply_on_req, 0);
		@(posedge sys_clk);
		rst_b <= 1;
		repeat (30) @(posedge sys_clk);
		wait_st(cps_pkg::ST_POR, 0);
		wait_st(cps_pkg::ST_OFF, 40);
		repeat (50) @(posedge sys_clk);
		chk("key off supply", supply_on_req, 0);
		wait_st(cps_pkg::ST_OFF, 0);
	endtask
	task t_power_up;
		key <= 1;
		wait_st(cps_pkg::ST_BULK, 20);
		while (rg !== 1'b1) @(posedge sys_clk);
		chk("no blower", mod_en_b, 3'h7);
		wait_st(cps_pkg::ST_REL, 100);
		chk("rel reset", sys_reset, 1);
		chk("rel en", mod_en_b, 3'h0);
		chk("rel warn", ac_low_warning, 0);
		wait_st(cps_pkg::ST_RUN, 100);
		chk("run reset", sys_reset, 0);
		apb(0, `CPS_OFF_EVENTS, 0);
		chk("ev run", d[`CPS_EV_RUN], 1);
		chk("ev ac", d[`CPS_EV_AC_BACK], 0);
	endtask
	task t_events;
		piu <= 3'h5;
		ot <= 1;
		repeat (5) @(posedge sys_clk);
		chk("piu", piu_status, 3'h5);
		apb(1, `CPS_OFF_MASK, 32'h00000008);
		repeat (2) @(posedge sys_clk);
		chk("irq on", irq, 1);
		apb(0, `CPS_OFF_EVENTS, 0);
		chk("ev temp", d[`CPS_EV_OVERTEMP], 1);
		repeat (3) @(posedge sys_clk);
		chk("irq off", irq, 0);
		apb(0, 12'h010, 0);
		chk("unmapped err", e, 1);
		chk("unmapped data", d, 0);
		chk("still run", sys_reset, 0);
		ot <= 0;
	endtask
	task t_freeze;
		ce <= 0;
		piu <= 3'h2;
		repeat (6) @(posedge sys_clk);
		chk("frozen ready", pready, 0);
		chk("frozen piu", piu_status, 3'h5);
		chk("frozen reset", sys_reset, 0);
		ce <= 1;
		repeat (4) @(posedge sys_clk);
		chk("thawed piu", piu_status, 3'h2);
		chk("thawed ready", pready, 1);
	endtask
	task t_power_fail;
		ac <= 0;
		wait_st(cps_pkg::ST_PDA, 100);
		chk("pda warn", ac_low_warning, 1);
		chk("pda en", mod_en_b, 3'h0);
		wait_st(cps_pkg::ST_PDR, 100);
		chk("pdr reset", sys_reset, 1);
		chk("pdr en", mod_en_b, 3'h0);
		wait_st(cps_pkg::ST_IDLE, 100);
		repeat (3) @(posedge sys_clk);
		chk("idle en", mod_en_b, 3'h7);
		repeat (100) @(posedge sys_clk);
		wait_st(cps_pkg::ST_IDLE, 0);
		apb(0, `CPS_OFF_EVENTS, 0);
		chk("ev pd", d[2:1], 2'h3);
		ac <= 1;
		wait_st(cps_pkg::ST_RUN, 300);
		chk("back en", mod_en_b, 3'h0);
	endtask
	task t_key_off;
		key <= 0;
		repeat (4) @(posedge sys_clk);
		chk("off reset", sys_reset, 1);
		chk("off warn", ac_low_warning, 1);
		repeat (2) @(posedge sys_clk);
		chk("off en", mod_en_b, 3'h7);
		wait_st(cps_pkg::ST_OFF, 0);
	endtask

	initial
	begin
		repeat (12) @(posedge sys_clk);
		t_reset;
		t_power_up;
		t_events;
		t_freeze;
		t_power_fail;
		t_key_off;
		tally_and_finish;
	end
	initial
	begin
		#2000000;
		failures++;
		tally_and_finish;
	end
endmodule
